// file: rtl/lccs_logic_cell_clock_select.sv
// Cluster pair: two combinational cells and one register cell each, plus
// clock networks and user I/O configuration. Assumes configuration ports
// are static while i_clock runs; clock selection is modelled as sampling
// the chosen network on i_clock with per-cell edge polarity.
//
// Behaviour
// - Register cell has async clear, async preset and an enable from two selects.
// - Each register cell picks its own active clock edge.
// - Each register cell clocks from the hard-wired or a routed clock.
// - Three clock networks exist: hard-wired plus two routed.
// - The hard-wired clock reaches only register clock selection.
// - The hard-wired clock never feeds combinational logic.
// - Each routed clock comes from its pin or internal logic, usable anywhere.
// - A cluster is two combinational cells and one register cell, paired.
// - Combinational cells do up to five-input functions, one input invertible.
// - Each I/O is input, output, tristate or bidirectional on its own.
// - During power-up each I/O pulls up, down, or stays tristated.
`timescale 1ns/100ps
`include "lccs_cfg.svh"

// One combinational cell: truth table over NIN inputs, input 0 invertible
module lccs_comb_cell
  import lccs_pkg::*;
#(
  parameter int NIN = `LCCS_LUT_INPUTS
) (
  input  wire logic [NIN-1:0]    i_inputs,
  input  wire logic              i_invert,
  input  wire logic [2**NIN-1:0] i_table,
  output logic                   o_out
);

  logic [NIN-1:0] sel;

  always_comb begin
    sel    = i_inputs;
    sel[0] = i_inputs[0] ^ i_invert;
    o_out  = i_table[sel];
  end

endmodule

// One register cell: edge pick, enable, async clear and preset
module lccs_reg_cell
  import lccs_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_net_clk,
  input  wire logic i_falling_edge,
  input  wire logic i_enable_select_0,
  input  wire logic i_enable_select_1,
  input  wire logic i_clear_n,
  input  wire logic i_preset_n,
  input  wire logic i_d,
  output logic      o_q
);

  logic net_q;
  logic seen_q;
  logic tick;
  logic enable;
  logic reg_q;

  // Previous level of the selected clock net
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      net_q <= 1'h0;
    end else begin
      net_q <= i_net_clk;
    end
  end

  // No edge until one real sample is held, so reset makes no false edge
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_q <= 1'h0;
    end else begin
      seen_q <= 1'h1;
    end
  end

  // Per-cell polarity
  assign tick = seen_q & (i_falling_edge ? (net_q & ~i_net_clk)
                                         : (~net_q & i_net_clk));
  // Enable from the two select lines
  assign enable = i_enable_select_0 | i_enable_select_1;

  always_ff @(posedge i_clock or negedge i_reset_n or negedge i_clear_n
              or negedge i_preset_n) begin
    if (!i_reset_n) begin
      reg_q <= `LCCS_RCELL_RESET;
    end else if (!i_clear_n) begin
      reg_q <= 1'h0;
    end else if (!i_preset_n) begin
      reg_q <= 1'h1;
    end else if (tick && enable) begin
      reg_q <= i_d;
    end
  end

  assign o_q = reg_q;

endmodule

module lccs_logic_cell_clock_select
  import lccs_pkg::*;
#(
  parameter int NCLU = `LCCS_CLUSTERS,
  parameter int NIO  = `LCCS_IO_COUNT
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_hardwired_clock,
  input  wire logic                    i_routed_clock_a_pin,
  input  wire logic                    i_routed_clock_b_pin,
  input  wire logic                    i_routed_clock_a_int,
  input  wire logic                    i_routed_clock_b_int,
  input  wire logic                    i_routed_clock_a_src_int,
  input  wire logic                    i_routed_clock_b_src_int,
  input  wire logic [NCLU*2*5-1:0]     i_cell_inputs,
  input  wire logic [NCLU*2-1:0]       i_invert_db,
  input  wire logic [NCLU*2*32-1:0]    i_cell_table,
  input  wire logic [NCLU-1:0]         i_use_routed,
  input  wire logic [NCLU-1:0]         i_routed_sel_b,
  input  wire logic [NCLU-1:0]         i_falling_edge,
  input  wire logic [NCLU-1:0]         i_enable_select_0,
  input  wire logic [NCLU-1:0]         i_enable_select_1,
  input  wire logic [NCLU-1:0]         i_clear_n,
  input  wire logic [NCLU-1:0]         i_preset_n,
  input  wire logic [NCLU-1:0]         i_dsel,
  input  wire logic                    i_power_up,
  input  wire logic [NIO*2-1:0]        i_io_mode,
  input  wire logic [NIO*2-1:0]        i_io_pull,
  input  wire logic [NIO-1:0]          i_io_out,
  input  wire logic [NIO-1:0]          i_io_oe_user,
  input  wire logic [NIO-1:0]          i_io_pad,
  output logic      [NCLU*2-1:0]       o_cell_out,
  output logic      [NCLU-1:0]         o_reg_out,
  output logic                         o_routed_clock_a,
  output logic                         o_routed_clock_b,
  output logic      [NIO-1:0]          o_io_pad,
  output logic      [NIO-1:0]          o_io_pad_oe,
  output logic      [NIO-1:0]          o_io_pull_up,
  output logic      [NIO-1:0]          o_io_pull_down,
  output logic      [NIO-1:0]          o_io_in
);

  // Routed clocks; pin left unused when internal source chosen
  logic clk_a;
  logic clk_b;
  assign clk_a = i_routed_clock_a_src_int ? i_routed_clock_a_int
                                          : i_routed_clock_a_pin;
  assign clk_b = i_routed_clock_b_src_int ? i_routed_clock_b_int
                                          : i_routed_clock_b_pin;
  // Routed clocks may feed logic outside; hard-wired one never leaves
  assign o_routed_clock_a = clk_a;
  assign o_routed_clock_b = clk_b;

  localparam int NIN   = `LCCS_LUT_INPUTS;
  localparam int NBITS = `LCCS_LUT_BITS;

  genvar c;
  generate
    for (c = 0; c < NCLU; c++) begin : g_clu
      wire logic [1:0] comb;
      logic            net_clk;
      logic            reg_d;

      // Two combinational cells per cluster
      for (genvar k = 0; k < 2; k++) begin : g_cell
        lccs_comb_cell #(
          .NIN (NIN)
        ) u_cell (
          .i_inputs (i_cell_inputs[(c*2+k)*NIN +: NIN]),
          .i_invert (i_invert_db[c*2+k]),
          .i_table  (i_cell_table[(c*2+k)*NBITS +: NBITS]),
          .o_out    (comb[k])
        );
      end
      assign o_cell_out[c*2 +: 2] = comb;

      // Clock select: hard-wired path only ends here
      assign net_clk = i_use_routed[c]
                     ? (i_routed_sel_b[c] ? clk_b : clk_a)
                     : i_hardwired_clock;

      // D from either cell of the cluster
      assign reg_d = i_dsel[c] ? comb[1] : comb[0];

      lccs_reg_cell u_reg (
        .i_clock           (i_clock),
        .i_reset_n         (i_reset_n),
        .i_net_clk         (net_clk),
        .i_falling_edge    (i_falling_edge[c]),
        .i_enable_select_0 (i_enable_select_0[c]),
        .i_enable_select_1 (i_enable_select_1[c]),
        .i_clear_n         (i_clear_n[c]),
        .i_preset_n        (i_preset_n[c]),
        .i_d               (reg_d),
        .o_q               (o_reg_out[c])
      );
    end
  endgenerate

  // I/O cells
  always_comb begin
    for (int i = 0; i < NIO; i++) begin
      lccs_io_mode_t m;
      lccs_pull_t    p;
      m = lccs_io_mode_t'(i_io_mode[i*2 +: 2]);
      p = lccs_pull_t'(i_io_pull[i*2 +: 2]);
      o_io_pad[i]       = i_io_out[i];
      o_io_in[i]        = 1'h0;
      o_io_pad_oe[i]    = 1'h0;
      o_io_pull_up[i]   = 1'h0;
      o_io_pull_down[i] = 1'h0;
      if (i_power_up) begin
        o_io_pull_up[i]   = (p == LCCS_PULL_UP);
        o_io_pull_down[i] = (p == LCCS_PULL_DOWN);
      end else begin
        unique case (m)
          LCCS_IO_INPUT:    o_io_in[i] = i_io_pad[i];
          LCCS_IO_OUTPUT:   o_io_pad_oe[i] = 1'h1;
          LCCS_IO_TRISTATE: o_io_pad_oe[i] = i_io_oe_user[i];
          LCCS_IO_BIDIR: begin
            o_io_pad_oe[i] = i_io_oe_user[i];
            o_io_in[i]     = i_io_pad[i];
          end
        endcase
      end
    end
  end

endmodule

// file: rtl/lccs_cfg.svh
// Constants for the logic cell cluster with clock selection.
// Assumes inclusion by bare name from the package and design files.
`ifndef LCCS_CFG_SVH
`define LCCS_CFG_SVH
`define LCCS_LUT_INPUTS    5
`define LCCS_LUT_BITS      32
`define LCCS_CELLS_PER_CLU 2
`define LCCS_CLUSTERS      2
`define LCCS_IO_COUNT      4
`define LCCS_ROUTED_CLOCKS 2
`define LCCS_CLK_NETWORKS  3
`define LCCS_RCELL_RESET   1'h0
`endif

// file: rtl/lccs_pkg.sv
// Types for the logic cell cluster with clock selection.
// Assumes the constants header is on the include path.
`include "lccs_cfg.svh"
package lccs_pkg;
  typedef enum logic [1:0] {
    LCCS_IO_INPUT,
    LCCS_IO_OUTPUT,
    LCCS_IO_TRISTATE,
    LCCS_IO_BIDIR
  } lccs_io_mode_t;
  typedef enum logic [1:0] {
    LCCS_PULL_NONE,
    LCCS_PULL_UP,
    LCCS_PULL_DOWN
  } lccs_pull_t;
endpackage

// file: test/lccs_clk_src.sv
// Board clock source: hard-wired clock and routed clock A pin.
// Assumes i_clock from the bench; pin tied low when sourced inside.
`timescale 1ns/100ps
module lccs_clk_src (
  input  wire logic i_clock,
  input  wire logic i_tie,
  output logic      o_hclk,
  output logic      o_pin_a
);
  initial o_hclk = 1'h0;
  always @(posedge i_clock) #5 o_hclk <= ~o_hclk;
  assign o_pin_a = i_tie ? 1'h0 : o_hclk;
endmodule

// file: test/lccs_cs_assertions.sv
// Checker: register cell 0, routed clock A, I/O configuration.
// Assumes binding to the design top by port name.
`timescale 1ns/100ps
module lccs_cs_assertions #(
  parameter int NCLU = 2,
  parameter int NIO  = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic             i_power_up,
  input  wire logic             o_routed_clock_a,
  input  wire logic             i_routed_clock_a_pin,
  input  wire logic             i_routed_clock_a_int,
  input  wire logic             i_routed_clock_a_src_int,
  input  wire logic [NCLU-1:0]  i_clear_n,
  input  wire logic [NCLU-1:0]  i_preset_n,
  input  wire logic [NCLU-1:0]  o_reg_out,
  input  wire logic [NCLU-1:0]  i_enable_select_0,
  input  wire logic [NCLU-1:0]  i_enable_select_1,
  input  wire logic [NIO*2-1:0] i_io_mode,
  input  wire logic [NIO*2-1:0] i_io_pull,
  input  wire logic [NIO-1:0]   o_io_pad_oe,
  input  wire logic [NIO-1:0]   o_io_pull_up
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Clear acts at once, without a clock edge
  property p_clr; !i_clear_n[0] |-> !o_reg_out[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear lost");
  property p_pre; (i_clear_n[0] && !i_preset_n[0]) ##1 i_clear_n[0]
    |-> o_reg_out[0]; endproperty
  a_pre: assert property (p_pre) else $error("preset lost");
  property p_hold; (i_clear_n[0] && i_preset_n[0] && !i_enable_select_0[0]
    && !i_enable_select_1[0]) ##1 (i_clear_n[0] && i_preset_n[0])
    |-> $stable(o_reg_out[0]); endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_rca; o_routed_clock_a == (i_routed_clock_a_src_int ?
    i_routed_clock_a_int : i_routed_clock_a_pin); endproperty
  a_rca: assert property (p_rca) else $error("routed source");
  property p_pwr; i_power_up |-> o_io_pad_oe == '0; endproperty
  a_pwr: assert property (p_pwr) else $error("driven at power-up");
  property p_pull; i_power_up |-> o_io_pull_up[0] == (i_io_pull[1:0] == 2'h1);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up");
  property p_in; !i_power_up && i_io_mode[1:0] == 2'h0 |-> !o_io_pad_oe[0];
  endproperty
  a_in: assert property (p_in) else $error("input drives");
  property p_out; !i_power_up && i_io_mode[1:0] == 2'h1 |-> o_io_pad_oe[0];
  endproperty
  a_out: assert property (p_out) else $error("output idle");
endmodule
bind lccs_logic_cell_clock_select lccs_cs_assertions #(.NCLU(NCLU), .NIO(NIO))
  u_chk (.*);

// file: test/testbench.sv
// Self-checking bench for the cluster pair.
// Assumes the package, clock source and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  logic i_clock, i_reset_n, i_routed_clock_a_int, i_routed_clock_b_int;
  logic i_routed_clock_a_src_int, i_routed_clock_b_src_int, i_power_up;
  logic i_routed_clock_b_pin, o_routed_clock_a, o_routed_clock_b;
  wire logic i_hardwired_clock, i_routed_clock_a_pin;
  logic [19:0] i_cell_inputs;
  logic [127:0] i_cell_table;
  logic [7:0] i_io_mode, i_io_pull;
  logic [3:0] i_invert_db, i_io_out, i_io_oe_user, i_io_pad, o_cell_out;
  logic [3:0] o_io_pad, o_io_pad_oe, o_io_pull_up, o_io_pull_down, o_io_in;
  logic [1:0] i_use_routed, i_routed_sel_b, i_falling_edge, i_dsel, o_reg_out;
  logic [1:0] i_enable_select_0, i_enable_select_1, i_clear_n, i_preset_n;
  int n_fail = 0, n_compared = 0;
  lccs_logic_cell_clock_select u_dut (.*);
  lccs_clk_src u_src (.i_clock, .i_tie(i_routed_clock_a_src_int),
    .o_hclk(i_hardwired_clock), .o_pin_a(i_routed_clock_a_pin));
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  task wait_q(input logic v);
    int k;
    for (k = 0; k < 40 && o_reg_out[0] !== v; k++) tick(1);
    chk(o_reg_out[0], v);
    if (k == 40) test_done;
  endtask
  task t_reg;
    i_preset_n[0] = 1'h0;
    tick(2);
    chk(o_reg_out[0], 1'h1);
    i_clear_n[0] = 1'h0;
    tick(2);
    chk(o_reg_out[0], 1'h0);
    i_clear_n = 2'h3;
    i_preset_n = 2'h3;
    tick(8);
    chk(o_reg_out[0], 1'h0);
    i_enable_select_1[0] = 1'h1;
    wait_q(1'h1);
    i_use_routed[0] = 1'h1;
    i_routed_clock_a_src_int = 1'h1;
    i_cell_table[31:0] = 32'h0;
    tick(4);
    chk(o_reg_out[0], 1'h1);
    i_routed_clock_a_int = 1'h1;
    wait_q(1'h0);
  endtask
  task t_clk;
    i_cell_table[127:96] = 32'hFFFF_FFFF;
    i_dsel[1] = 1'h1;
    i_use_routed[1] = 1'h1;
    i_routed_sel_b[1] = 1'h1;
    i_falling_edge[1] = 1'h1;
    tick(3);
    chk(o_reg_out[1], 1'h0);
    i_enable_select_0[1] = 1'h1;
    i_routed_clock_b_pin = 1'h1;
    tick(4);
    chk(o_routed_clock_b, 1'h1);
    chk(o_reg_out[1], 1'h0);
    i_routed_clock_b_pin = 1'h0;
    tick(2);
    chk(o_routed_clock_b, 1'h0);
    chk(o_reg_out[1], 1'h1);
  endtask
  task t_io;
    chk(o_cell_out[1], 1'h1);
    i_invert_db = 4'h0;
    i_power_up = 1'h1;
    tick(1);
    chk(o_cell_out[1], 1'h0);
    chk(o_io_pad_oe, 4'h0);
    chk(o_io_pull_up, 4'h1);
    chk(o_io_pull_down, 4'h2);
    i_power_up = 1'h0;
    tick(1);
    chk(o_io_pad_oe, 4'hE);
    chk(o_io_in, 4'h1);
    i_io_out = 4'hA;
    i_io_pad = 4'hB;
    tick(1);
    chk(o_io_pad, 4'hA);
    chk(o_io_in, 4'h9);
  endtask
  initial begin
    {i_reset_n, i_power_up, i_cell_inputs, i_use_routed, i_routed_sel_b} = '0;
    {i_falling_edge, i_dsel, i_enable_select_0, i_enable_select_1} = '0;
    {i_routed_clock_a_int, i_routed_clock_b_int, i_routed_clock_b_pin} = '0;
    {i_routed_clock_a_src_int, i_routed_clock_b_src_int, i_io_out} = '0;
    {i_clear_n, i_preset_n, i_invert_db, i_io_pad} = 12'hF25;
    {i_io_mode, i_io_pull, i_io_oe_user} = 20'hE409C;
    i_cell_table = {64'h0, 32'h2, 32'hFFFF_FFFF};
    repeat (8) @(posedge i_clock);
    #2 i_reset_n = 1'h1;
    t_reg;
    t_clk;
    t_io;
    test_done;
  end
endmodule
